// >>> sar_pkg.sv
// Package: timing, states and codes of the conversion sequencer
package sar_pkg;
	localparam int RES_BITS       = 16;
	localparam int CLK_SYS_MHZ    = 25;
	localparam int APERTURE_NS    = 40;
	localparam int APERTURE_CYC   = (APERTURE_NS * CLK_SYS_MHZ + 999) / 1000 < 1 ? 1 :
		(APERTURE_NS * CLK_SYS_MHZ + 999) / 1000;
	localparam int SWITCH_NS      = 40;
	localparam int SWITCH_CYC     = (SWITCH_NS * CLK_SYS_MHZ + 999) / 1000 < 1 ? 1 :
		(SWITCH_NS * CLK_SYS_MHZ + 999) / 1000;
	localparam int THROUGHPUT_NS  = 1000;
	localparam int CYCLE_CYC      = (THROUGHPUT_NS * CLK_SYS_MHZ) / 1000;
	localparam int WAKE_CYC       = 1;
	localparam logic [15:0] CODE_ZERO = 16'h0000;
	localparam logic [15:0] CODE_MID  = 16'h8000;
	localparam logic [15:0] CODE_FULL = 16'hFFFF;
	localparam int CNT_W          = 8;

	typedef enum logic [2:0] {
		ST_SLEEP    = 3'b000,
		ST_WAKE     = 3'b001,
		ST_ACQ      = 3'b010,
		ST_APERTURE = 3'b011,
		ST_GND_OPEN = 3'b100,
		ST_ARRAY    = 3'b101,
		ST_SAR      = 3'b110,
		ST_DONE     = 3'b111
	} seq_state_t;
endpackage

// >>> sar_register.sv
// Successive-approximation trial register, one bit decided per step
`timescale 1ns/100ps
module sar_register #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk_sys,   // System clock
	input  wire logic             resetn,    // Async reset, active low
	input  wire logic             start,     // Load MSB trial
	input  wire logic             step,      // Apply one comparator decision
	input  wire logic             comp_keep, // Comparator says keep trial bit
	output logic [WIDTH-1:0]      trial,     // Current DAC setting
	output logic                  last       // Final bit being decided
);
	logic [WIDTH-1:0] mask_reg;
	logic [WIDTH-1:0] trial_reg;

	assign trial = trial_reg;
	assign last  = mask_reg[0];

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mask_reg <= '0;
		end else if (start) begin
			mask_reg <= {1'b1, {(WIDTH-1){1'b0}}};
		end else if (step) begin
			mask_reg <= mask_reg >> 1;
		end
	end

	// Per-bit decision: drop a rejected trial, set the next weight
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk_sys or negedge resetn) begin
				if (!resetn) begin
					trial_reg[i] <= 1'b0;
				end else if (start) begin
					trial_reg[i] <= (i == WIDTH - 1);
				end else if (step) begin
					if (mask_reg[i] && !comp_keep) begin
						trial_reg[i] <= 1'b0;
					end else if (i < WIDTH - 1 && mask_reg[(i + 1) % WIDTH]) begin
						trial_reg[i] <= 1'b1;
					end
				end else begin
					trial_reg[i] <= 1'b0; // Idle DAC rests at zero
				end
			end
		end
	endgenerate
endmodule

// >>> sar_conversion_sequencer.sv
// Conversion sequencer of a 16-bit charge-redistribution converter
`timescale 1ns/100ps
// Summary of operation
// - After acquisition, convert strobe rising edge starts the conversion phase.
// - Open comparator ground switches first, then ground both capacitor arrays.
// - Resolve 16 binary-weighted elements, MSB first, down to one LSB.
// - On completion return to acquisition, form the code, drop busy indication.
// - Steps timed by internal clock, never by serial clock.
// - Output is 16-bit straight binary: 0000, 8000 midscale, FFFF.
// - Overrange input saturates to all ones, never wraps.
// - Underrange input saturates to all zeros, never wraps.
// - Result belongs to the sample of the same strobe, no latency.
// - Powered down between conversions, waking only for the next one.
// - Conversion plus acquisition fits one million conversions per second.
// - Input is held a fixed aperture delay after the strobe edge.
module sar_conversion_sequencer #(
	parameter int WIDTH = sar_pkg::RES_BITS
) (
	input  wire logic             clk_sys,                      // 25 MHz system clock
	input  wire logic             resetn,                       // Async reset, active low
	input  wire logic             convert_strobe,               // Conversion start strobe
	input  wire logic             serial_data_in,               // Mode select level
	input  wire logic             comparator_out,               // High: input above DAC
	input  wire logic             over_range,                   // Input above full scale
	input  wire logic             under_range,                  // Input below ground
	output logic                  positive_array_ground_switch, // Closed when high
	output logic                  negative_array_ground_switch, // Closed when high
	output logic                  array_to_input,               // Arrays track inputs
	output logic                  track_hold,                   // High: input held
	output logic [WIDTH-1:0]      dac_code,                     // Capacitor switch setting
	output logic                  power_up,                     // Analog core powered
	output logic                  conv_busy,                    // Conversion in progress
	output logic                  conv_done,                    // One-cycle completion pulse
	output logic [WIDTH-1:0]      result_code,                  // Held output code
	output logic                  chain_mode                    // Latched interface mode
);
	import sar_pkg::*;

	seq_state_t       state_reg;
	seq_state_t       state_next;
	logic [CNT_W-1:0] cnt_reg;
	logic             strobe_d_reg;
	logic             strobe_rise;
	logic             sar_start;
	logic             sar_step;
	logic             sar_last;
	logic             ovr_reg;
	logic             udr_reg;

	localparam logic [CNT_W-1:0] APER_LAST = CNT_W'(APERTURE_CYC - 1);
	localparam logic [CNT_W-1:0] SW_LAST   = CNT_W'(SWITCH_CYC - 1);

	assign strobe_rise = convert_strobe && !strobe_d_reg;
	assign sar_start   = (state_reg == ST_ARRAY) && (cnt_reg == SW_LAST);
	assign sar_step    = (state_reg == ST_SAR);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			strobe_d_reg <= 1'b0;
		end else begin
			strobe_d_reg <= convert_strobe;
		end
	end

	// Sequencing runs from clk_sys only; serial clock never enters here
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_SLEEP:    if (strobe_rise) state_next = ST_APERTURE;
			ST_WAKE:     state_next = ST_ACQ;
			ST_ACQ:      if (strobe_rise) state_next = ST_APERTURE;
			ST_APERTURE: if (cnt_reg == APER_LAST) state_next = ST_GND_OPEN;
			ST_GND_OPEN: if (cnt_reg == SW_LAST) state_next = ST_ARRAY;
			ST_ARRAY:    if (cnt_reg == SW_LAST) state_next = ST_SAR;
			ST_SAR:      if (sar_last) state_next = ST_DONE;
			ST_DONE:     state_next = ST_SLEEP;
			default:     state_next = ST_SLEEP;
		endcase
	end

	// Strobe edges inside a conversion are ignored by the case above
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_SLEEP;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= '0;
		end else if (state_next != state_reg) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + CNT_W'(1);
		end
	end

	sar_register #(
		.WIDTH(WIDTH)
	) u_sar (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.start    (sar_start),
		.step     (sar_step),
		.comp_keep(comparator_out),
		.trial    (dac_code), // Straight from the trial flops, no lag to the comparator
		.last     (sar_last)
	);

	// Range flags caught at hold time so they match this sample
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ovr_reg <= 1'b0;
			udr_reg <= 1'b0;
		end else if (state_reg == ST_APERTURE && cnt_reg == APER_LAST) begin
			ovr_reg <= over_range;
			udr_reg <= under_range;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			chain_mode <= 1'b0;
		end else if (strobe_rise && (state_reg == ST_ACQ || state_reg == ST_SLEEP)) begin
			chain_mode <= !serial_data_in;
		end
	end

	// Final bit folded in here; saturation beats the search result
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			result_code <= CODE_ZERO;
		end else if (state_reg == ST_SAR && sar_last) begin
			if (ovr_reg) begin
				result_code <= CODE_FULL;
			end else if (udr_reg) begin
				result_code <= CODE_ZERO;
			end else begin
				result_code <= {dac_code[WIDTH-1:1], comparator_out};
			end
		end
	end // Held until next completion

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			positive_array_ground_switch <= 1'b0;
			negative_array_ground_switch <= 1'b0;
			array_to_input               <= 1'b0;
			track_hold                   <= 1'b0;
			power_up                     <= 1'b0;
			conv_busy                    <= 1'b0;
			conv_done                    <= 1'b0;
		end else begin
			positive_array_ground_switch <= (state_next == ST_ACQ || state_next == ST_SLEEP ||
				state_next == ST_APERTURE || state_next == ST_DONE);
			negative_array_ground_switch <= (state_next == ST_ACQ || state_next == ST_SLEEP ||
				state_next == ST_APERTURE || state_next == ST_DONE);
			array_to_input               <= (state_next == ST_ACQ || state_next == ST_SLEEP ||
				state_next == ST_APERTURE || state_next == ST_GND_OPEN ||
				state_next == ST_DONE);
			track_hold                   <= (state_next == ST_GND_OPEN || state_next == ST_ARRAY ||
				state_next == ST_SAR);
			power_up                     <= (state_next != ST_SLEEP);
			conv_busy                    <= (state_next == ST_APERTURE || state_next == ST_GND_OPEN
				|| state_next == ST_ARRAY || state_next == ST_SAR);
			conv_done                    <= (state_next == ST_DONE);
		end
	end

	// Worst-case sample period in clk_sys cycles, for the rate check
	localparam int CONV_TOTAL = 1 + APERTURE_CYC + 2 * SWITCH_CYC + WIDTH + 2;
	int period_cnt;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			period_cnt <= 0;
		end else if (state_reg == ST_APERTURE && cnt_reg == '0) begin
			period_cnt <= 1;
		end else if (conv_busy && period_cnt < 255) begin
			period_cnt <= period_cnt + 1;
		end
	end

	// Cycles spent in SAR, for the step count check
	int sar_cycles;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sar_cycles <= 0;
		end else if (state_reg == ST_SAR) begin
			sar_cycles <= sar_cycles + 1;
		end else begin
			sar_cycles <= 0;
		end
	end

	sequence s_gnd_open;
		(state_reg == ST_GND_OPEN) && !positive_array_ground_switch &&
		!negative_array_ground_switch && array_to_input;
	endsequence
	sequence s_arrays_grounded;
		(state_reg == ST_ARRAY) && !array_to_input;
	endsequence

	switch_order_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(state_reg == ST_GND_OPEN) |-> s_gnd_open ##[1:4] s_arrays_grounded)
		else $error("ground switches not opened before arrays grounded");

	sar_length_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(state_reg == ST_SAR && state_next != ST_SAR) |-> sar_cycles == WIDTH - 1 ##1
		state_reg == ST_DONE)
		else $error("approximation did not take sixteen steps");

	done_pulse_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		conv_done |-> !conv_busy ##1 !conv_done)
		else $error("completion pulse wrong");

	overrange_sat_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(state_reg == ST_SAR && sar_last && ovr_reg) |=> result_code == CODE_FULL)
		else $error("overrange not saturated");

	underrange_sat_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(state_reg == ST_SAR && sar_last && udr_reg && !ovr_reg) |=> result_code == CODE_ZERO)
		else $error("underrange not saturated");

	sleep_between_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		conv_done |=> !power_up)
		else $error("not powered down after conversion");

	rate_budget_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		period_cnt <= CYCLE_CYC)
		else $error("conversion exceeds sample period");

	aperture_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(strobe_rise && state_reg == ST_SLEEP) |=> !track_hold ##1 track_hold[*1] or
		(!track_hold ##1 !track_hold ##1 track_hold))
		else $error("hold not after aperture delay");

	result_stable_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		!(state_reg == ST_SAR && sar_last) |=> $stable(result_code))
		else $error("held code changed outside completion");

	no_restart_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		(state_reg == ST_SAR && strobe_rise && !sar_last) |=> state_reg == ST_SAR)
		else $error("strobe disturbed a conversion");
endmodule

// >>> sar_input_model.sv
// Analog front end model: ideal comparator against a held input level
`timescale 1ns/100ps
module sar_input_model (
	input  wire logic [15:0] dac_code,       // Trial from the sequencer
	input  wire logic [15:0] input_level,    // Held input as an ideal code
	output logic             comparator_out  // High: input at or above trial
);
	// Level compare, so a slow DAC update shows up as a wrong bit, not a hang
	assign comparator_out = (input_level >= dac_code);
endmodule

// >>> sar_conversion_sequencer_tb.sv
// Self-checking bench of the conversion sequencer
`timescale 1ns/100ps
module sar_conversion_sequencer_tb;
	import sar_pkg::*;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic        convert_strobe = 1'b0;
	logic        serial_data_in = 1'b1;
	logic        comparator_out;
	logic        over_range = 1'b0;
	logic        under_range = 1'b0;
	logic        pos_sw, neg_sw, array_to_input, track_hold, power_up, conv_busy, conv_done;
	logic        chain_mode;
	logic [15:0] dac_code, result_code, input_level = 16'h0000;
	int          n_fail = 0;
	int          checked = 0;
	localparam int DONE_CYC = APERTURE_CYC + 2 * SWITCH_CYC + RES_BITS; // Take edge to done

	always #20 clk_sys = ~clk_sys;

	sar_input_model host (
		.dac_code       (dac_code),
		.input_level    (input_level),
		.comparator_out (comparator_out)
	);

	sar_conversion_sequencer dut (
		.clk_sys                      (clk_sys),
		.resetn                       (resetn),
		.convert_strobe               (convert_strobe),
		.serial_data_in               (serial_data_in),
		.comparator_out               (comparator_out),
		.over_range                   (over_range),
		.under_range                  (under_range),
		.positive_array_ground_switch (pos_sw),
		.negative_array_ground_switch (neg_sw),
		.array_to_input               (array_to_input),
		.track_hold                   (track_hold),
		.dac_code                     (dac_code),
		.power_up                     (power_up),
		.conv_busy                    (conv_busy),
		.conv_done                    (conv_done),
		.result_code                  (result_code),
		.chain_mode                   (chain_mode)
	);

	task automatic print_verdict;
		if (n_fail == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check_code(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %0t code %h want %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %0t flag %b want %b", $time, got, exp);
		end
	endtask

	// One conversion; restrobe fires a second edge mid-conversion with flipped mode
	task automatic convert(input logic [15:0] lvl, input logic ovr, input logic und,
		input logic sdi, input logic restrobe, input logic [15:0] expv);
		int n;
		int t_sw;
		int t_arr;
		int t_hold;
		int t_busy;
		n = -1;
		t_sw = -1;
		t_arr = -1;
		t_hold = -1;
		t_busy = -1;
		@(posedge clk_sys);
		input_level <= lvl;
		over_range <= ovr;
		under_range <= und;
		serial_data_in <= sdi;
		convert_strobe <= 1'b1;
		#1;
		check_bit(power_up, 1'b0);
		do begin
			@(posedge clk_sys);
			n++;
			if (restrobe && n == 5) convert_strobe <= 1'b0;
			if (restrobe && n == 8) begin
				convert_strobe <= 1'b1;
				serial_data_in <= ~sdi;
			end
			#1;
			if (t_sw < 0 && pos_sw === 1'b0 && neg_sw === 1'b0) t_sw = n;
			if (t_arr < 0 && array_to_input === 1'b0) t_arr = n;
			if (t_hold < 0 && track_hold === 1'b1) t_hold = n;
			if (t_busy < 0 && conv_busy === 1'b1) t_busy = n;
			if (n > 40) begin
				n_fail++;
				print_verdict();
			end
		end while (conv_done !== 1'b1);
		check_bit(n == DONE_CYC, 1'b1);
		check_bit(n < CYCLE_CYC, 1'b1);
		check_bit(t_busy == 0, 1'b1);
		check_bit(t_sw >= 0 && t_sw < t_arr, 1'b1);
		check_bit(t_hold == APERTURE_CYC, 1'b1);
		check_code(result_code, expv);
		check_bit(chain_mode, ~sdi);
		check_bit(conv_busy, 1'b0);
		check_bit(array_to_input, 1'b1);
		check_bit(pos_sw && neg_sw, 1'b1);
		@(posedge clk_sys);
		convert_strobe <= 1'b0;
		input_level <= ~lvl;
		#1;
		check_bit(power_up, 1'b0);
		repeat (2) @(posedge clk_sys);
		#1;
		check_code(result_code, expv);
	endtask

	task automatic run_codes;
		logic [15:0] lv [6] = '{16'h0000, 16'h8000, 16'hFFFF, 16'h7FFF, 16'h0001, 16'hA5C3};
		foreach (lv[i]) convert(lv[i], 1'b0, 1'b0, i[0], 1'b0, lv[i]);
	endtask

	task automatic run_saturation;
		convert(16'h1234, 1'b1, 1'b0, 1'b1, 1'b0, CODE_FULL);
		convert(16'hF000, 1'b0, 1'b1, 1'b0, 1'b0, CODE_ZERO);
		convert(16'h4321, 1'b1, 1'b1, 1'b1, 1'b0, CODE_FULL);
	endtask

	task automatic run_restrobe;
		convert(16'h3C5A, 1'b0, 1'b0, 1'b1, 1'b1, 16'h3C5A);
		convert(16'hC3A5, 1'b0, 1'b0, 1'b0, 1'b1, 16'hC3A5);
	endtask

	initial begin
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		#1;
		check_code(result_code, 16'h0000);
		check_bit(power_up, 1'b0);
		run_codes();
		run_saturation();
		run_restrobe();
		print_verdict();
	end
endmodule
